//--- shared/cammem_pkg.sv
// shared constants and types of the content-addressable memory tile
package cammem_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned CAM_WORDS = 32; // stored words
  localparam int unsigned CAM_WIDTH = 32; // bits per word
  localparam int unsigned CAM_AW = 5; // address bits
  localparam int unsigned CAM_MAP_W = 16; // one-hot lines per output cycle

  // ----------------------------------------------------------------
  // values after reset or clear
  // ----------------------------------------------------------------
  localparam logic [CAM_WIDTH-1:0] CAM_RST_WORD = 32'h0000_0000; // cleared data
  localparam logic [CAM_AW-1:0] CAM_RST_ADDR = 5'h00; // cleared address
  localparam logic [CAM_MAP_W-1:0] CAM_RST_MAP = 16'h0000; // cleared map
  localparam logic [CAM_WORDS-1:0] CAM_RST_HITS = 32'h0000_0000; // no hits

  // ----------------------------------------------------------------
  // write sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMW_IDLE, // waiting for a new write
    CMW_DATA, // word commit cycle
    CMW_MASK // don't-care commit cycle
  } cammem_wr_state_t;

endpackage : cammem_pkg

//--- core/cammem_store.sv
// word storage, don't-care bits and parallel comparators
`timescale 1ns/10ps
module cammem_store #(
  parameter logic [31:0][31:0] INIT_WORDS = '0, // preloaded words
  parameter logic [31:0][31:0] INIT_DONT_CARE = '0, // preloaded masks
  parameter logic [31:0] INIT_VALID = '0 // preloaded entries in use
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic data_we_in,
  input wire logic care_we_in,
  input wire logic keep_invalid_in,
  input wire logic [cammem_pkg::CAM_AW-1:0] addr_in,
  input wire logic [cammem_pkg::CAM_WIDTH-1:0] data_in,
  input wire logic [cammem_pkg::CAM_WIDTH-1:0] dont_care_in,
  input wire logic [cammem_pkg::CAM_WIDTH-1:0] key_in,
  output logic [cammem_pkg::CAM_WORDS-1:0] hits_out
);

  // ----------------------------------------------------------------
  // state: one bit of care per data bit, one valid per entry
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0][31:0] word; // stored data
    logic [31:0][31:0] care; // 1 = bit takes part in compare
    logic [31:0] valid; // entry may match
  } cammem_store_st_t;

  cammem_store_st_t st; // registered contents
  cammem_store_st_t next_st; // next contents

  // write port: data cycle then optional care cycle
  always_comb
  begin
    next_st = st;
    if (data_we_in)
    begin
      next_st.word[addr_in] = data_in; // RULE5
      next_st.care[addr_in] = '1;
      next_st.valid[addr_in] = ~keep_invalid_in;
    end
    if (care_we_in)
    begin
      next_st.care[addr_in] = ~dont_care_in; // RULE6
      next_st.valid[addr_in] = 1'b1;
    end
  end

  // contents are only reset by the chip-wide reset, to the preload image
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      st <= '{word: INIT_WORDS, care: ~INIT_DONT_CARE, valid: INIT_VALID}; // RULE10
    else
      st <= next_st; // RULE10
  end

  // one comparator per entry, masked bits never block a hit
  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_cmp
      assign hits_out[g] = st.valid[g] & ~|((key_in ^ st.word[g]) & st.care[g]); // RULE6
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_word_stored;
    @(posedge sys_clk_in) disable iff (reset_in)
    $past(data_we_in) |-> st.word[$past(addr_in)] == $past(data_in);
  endproperty
  a_word_stored: assert property (p_word_stored) // RULE5
    else $error("written word not stored");

  property p_mask_stored;
    @(posedge sys_clk_in) disable iff (reset_in)
    $past(care_we_in) |-> st.care[$past(addr_in)] == ~$past(dont_care_in)
      && st.valid[$past(addr_in)];
  endproperty
  a_mask_stored: assert property (p_mask_stored) // RULE6
    else $error("don't-care bits not stored");

endmodule : cammem_store

//--- core/cammem_write_seq.sv
// write sequencer: two cycles per word, three with don't-care bits
`timescale 1ns/10ps
module cammem_write_seq (
  input wire logic sys_clk_in,
  input wire logic clr_in,
  input wire logic ena_in,
  input wire logic strobe_in,
  input wire logic [cammem_pkg::CAM_AW-1:0] addr_in,
  input wire logic [cammem_pkg::CAM_WIDTH-1:0] data_in,
  input wire logic [cammem_pkg::CAM_WIDTH-1:0] dont_care_in,
  output logic busy_out,
  output logic data_we_out,
  output logic care_we_out,
  output logic keep_invalid_out,
  output logic [cammem_pkg::CAM_AW-1:0] addr_out,
  output logic [cammem_pkg::CAM_WIDTH-1:0] data_out,
  output logic [cammem_pkg::CAM_WIDTH-1:0] dont_care_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cammem_pkg::cammem_wr_state_t state; // sequence step
    logic prev; // strobe one enabled cycle ago
    logic masked; // word carries don't-care bits
    logic [4:0] addr; // latched address
    logic [31:0] data; // latched data
    logic [31:0] dc; // latched don't-care bits
  } cammem_seq_st_t;

  cammem_seq_st_t st; // registered state
  cammem_seq_st_t next_st; // next state

  // start on a new strobe; a strobe dropped early aborts the write
  always_comb
  begin
    next_st = st;
    data_we_out = 1'b0;
    care_we_out = 1'b0;
    if (ena_in)
    begin
      next_st.prev = strobe_in;
      case (st.state)
        cammem_pkg::CMW_IDLE:
        begin
          // edge, not level, so a held strobe writes once
          if (strobe_in && !st.prev)
          begin
            next_st.state = cammem_pkg::CMW_DATA;
            next_st.addr = addr_in;
            next_st.data = data_in;
            next_st.dc = dont_care_in;
            next_st.masked = |dont_care_in;
          end
        end
        cammem_pkg::CMW_DATA:
        begin
          if (!strobe_in)
            next_st.state = cammem_pkg::CMW_IDLE;
          else
          begin
            data_we_out = 1'b1; // RULE11
            next_st.state = st.masked ? cammem_pkg::CMW_MASK : cammem_pkg::CMW_IDLE; // RULE11
          end
        end
        cammem_pkg::CMW_MASK:
        begin
          // an abort here leaves the half-written word unable to match
          care_we_out = strobe_in; // RULE11
          next_st.state = cammem_pkg::CMW_IDLE;
        end
        default:
          next_st.state = cammem_pkg::CMW_IDLE;
      endcase
    end
  end

  // input-side clear
  always_ff @(posedge sys_clk_in or posedge clr_in)
  begin
    if (clr_in)
      st <= '{state: cammem_pkg::CMW_IDLE, prev: 1'b0, masked: 1'b0,
              addr: cammem_pkg::CAM_RST_ADDR, data: cammem_pkg::CAM_RST_WORD,
              dc: cammem_pkg::CAM_RST_WORD};
    else
      st <= next_st;
  end

  assign busy_out = (st.state != cammem_pkg::CMW_IDLE);
  assign keep_invalid_out = st.masked;
  assign addr_out = st.addr;
  assign data_out = st.data;
  assign dont_care_out = st.dc;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_mask_third;
    @(posedge sys_clk_in) disable iff (clr_in)
    (st.state == cammem_pkg::CMW_DATA && ena_in && strobe_in && st.masked)
      |=> st.state == cammem_pkg::CMW_MASK ##1 st.state == cammem_pkg::CMW_IDLE;
  endproperty
  a_mask_third: assert property (p_mask_third) // RULE11
    else $error("masked write did not take three cycles");

  property p_plain_two;
    @(posedge sys_clk_in) disable iff (clr_in)
    (st.state == cammem_pkg::CMW_DATA && ena_in && strobe_in && !st.masked)
      |-> data_we_out ##1 st.state == cammem_pkg::CMW_IDLE;
  endproperty
  a_plain_two: assert property (p_plain_two) // RULE11
    else $error("plain write did not end after two cycles");

endmodule : cammem_write_seq

//--- core/cammem_top.sv
// content-addressable memory tile in input/output register mode
`timescale 1ns/10ps

// Summary of operation
// RULE1: input side registers data, strobes, addresses
// RULE2: output registers advance on their own side
// RULE3: separate enables and clears per side
// RULE4: local, global or chip reset clears registers
// RULE5: thirty-two words of thirty-two bits compared
// RULE6: don't-care bits never block a match
// RULE7: encoded mode gives matching word's address
// RULE8: unencoded map over two sixteen-bit cycles
// RULE9: user avoids duplicates with encoded output
// RULE10: preload at configuration, rewrite at run time
// RULE11: write takes two cycles, three when masked
// RULE12: low sixteen words first, then high sixteen
// RULE13: match-found flag beside encoded address
module cammem_top #(
  parameter logic [31:0][31:0] INIT_WORDS = '0, // preload image
  parameter logic [31:0][31:0] INIT_DONT_CARE = '0, // preload masks
  parameter logic [31:0] INIT_VALID = '0 // preloaded entries
) (
  input wire logic sys_clk_in, // single system clock
  input wire logic reset_in, // chip-wide reset
  input wire logic global_clr_in, // clear from the global network
  input wire logic in_clr_in, // local clear, input side
  input wire logic in_ena_in, // clock enable, input side
  input wire logic out_clr_in, // local clear, output side
  input wire logic out_ena_in, // clock enable, output side
  input wire logic write_strobe_in, // write request, held
  input wire logic [cammem_pkg::CAM_AW-1:0] wr_addr_in, // write address
  input wire logic [cammem_pkg::CAM_WIDTH-1:0] wr_data_in, // write data
  input wire logic [cammem_pkg::CAM_WIDTH-1:0] wr_dont_care_in, // 1 = ignore
  input wire logic fetch_strobe_in, // search request
  input wire logic [cammem_pkg::CAM_WIDTH-1:0] search_key_in, // search key
  input wire logic encoded_sel_in, // 1 = encoded, 0 = one-hot map
  output logic write_busy_out, // write sequence running
  output logic result_valid_out, // result cycle
  output logic match_found_out, // at least one hit
  output logic [cammem_pkg::CAM_AW-1:0] match_addr_out, // encoded address
  output logic [cammem_pkg::CAM_MAP_W-1:0] match_map_out, // one-hot half map
  output logic map_upper_out // map shows words 16 to 31
);

  // ----------------------------------------------------------------
  // clears
  // ----------------------------------------------------------------
  // the ors feed async resets; sources are registered elsewhere so no glitches
  logic in_clear; // input-side clear
  logic out_clear; // output-side clear
  assign in_clear = reset_in | global_clr_in | in_clr_in; // RULE4
  assign out_clear = reset_in | global_clr_in | out_clr_in; // RULE4

  // ----------------------------------------------------------------
  // input registers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr; // write strobe
    logic [4:0] addr; // write address
    logic [31:0] data; // write data
    logic [31:0] dc; // don't-care bits
    logic srch; // search strobe
    logic [31:0] key; // search key
    logic enc; // encoded output wanted
  } cammem_in_st_t;

  cammem_in_st_t in_q; // registered inputs
  cammem_in_st_t next_in; // next inputs

  // every write, search and mode input is sampled first; clears and enables are not
  always_comb
  begin
    next_in = in_q;
    if (in_ena_in)
    begin
      next_in.wr = write_strobe_in; // RULE1
      next_in.addr = wr_addr_in; // RULE1
      next_in.data = wr_data_in; // RULE1
      next_in.dc = wr_dont_care_in; // RULE1
      next_in.srch = fetch_strobe_in; // RULE1
      next_in.key = search_key_in; // RULE1
      next_in.enc = encoded_sel_in; // RULE1
    end
  end

  // input side only: its own enable and its own clear
  always_ff @(posedge sys_clk_in or posedge in_clear)
  begin
    if (in_clear)
      in_q <= '{wr: 1'b0, addr: cammem_pkg::CAM_RST_ADDR,
                data: cammem_pkg::CAM_RST_WORD, dc: cammem_pkg::CAM_RST_WORD,
                srch: 1'b0, key: cammem_pkg::CAM_RST_WORD, enc: 1'b0}; // RULE3
    else
      in_q <= next_in;
  end

  // ----------------------------------------------------------------
  // write path and storage
  // ----------------------------------------------------------------
  logic seq_data_we; // commit word
  logic seq_care_we; // commit don't-care bits
  logic seq_keep_invalid; // word waits for its mask
  logic [4:0] seq_addr; // target entry
  logic [31:0] seq_data; // word to store
  logic [31:0] seq_dc; // mask to store
  logic [31:0] hits; // live compare result

  // writes gated by the input-side enable
  cammem_write_seq u_seq (
    .sys_clk_in(sys_clk_in),
    .clr_in(in_clear),
    .ena_in(in_ena_in),
    .strobe_in(in_q.wr),
    .addr_in(in_q.addr),
    .data_in(in_q.data),
    .dont_care_in(in_q.dc),
    .busy_out(write_busy_out),
    .data_we_out(seq_data_we),
    .care_we_out(seq_care_we),
    .keep_invalid_out(seq_keep_invalid),
    .addr_out(seq_addr),
    .data_out(seq_data),
    .dont_care_out(seq_dc)
  );

  // memory array, preloadable; only the chip reset restores the image
  cammem_store #(
    .INIT_WORDS(INIT_WORDS),
    .INIT_DONT_CARE(INIT_DONT_CARE),
    .INIT_VALID(INIT_VALID)
  ) u_store (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .data_we_in(seq_data_we),
    .care_we_in(seq_care_we),
    .keep_invalid_in(seq_keep_invalid),
    .addr_in(seq_addr),
    .data_in(seq_data),
    .dont_care_in(seq_dc),
    .key_in(in_q.key),
    .hits_out(hits)
  );

  // ----------------------------------------------------------------
  // encoder
  // ----------------------------------------------------------------
  // lowest matching index wins; with duplicates that hides the others
  function automatic logic [4:0] cammem_encode(input logic [31:0] v);
    logic [4:0] a;
    a = cammem_pkg::CAM_RST_ADDR;
    for (int i = 31; i >= 0; i--)
    begin
      if (v[i])
        a = 5'(i);
    end
    return a;
  endfunction : cammem_encode

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid; // result cycle
    logic found; // any hit
    logic [4:0] addr; // encoded address
    logic [15:0] map; // half map
    logic upper; // half shown
    logic [31:0] hold; // captured hits
    logic pend; // result waiting for the output enable
    logic hi_pend; // upper half still to show
    logic enc; // mode of the held result
  } cammem_out_st_t;

  cammem_out_st_t out_q; // registered outputs
  cammem_out_st_t next_out; // next outputs
  logic [31:0] src_hits; // hits the next result is built from

  // a fresh search replaces any held result
  assign src_hits = in_q.srch ? hits : out_q.hold;

  // capture always, present only on enabled cycles so a result waits for the output enable
  always_comb
  begin
    next_out = out_q;
    if (in_q.srch)
    begin
      next_out.hold = hits;
      next_out.pend = 1'b1;
      next_out.hi_pend = 1'b0;
      next_out.enc = in_q.enc;
    end
    if (out_ena_in)
    begin
      next_out.valid = 1'b0; // RULE2
      if (next_out.pend)
      begin
        next_out.valid = 1'b1;
        next_out.found = |next_out.hold; // RULE13
        next_out.addr = cammem_encode(next_out.hold); // RULE7
        next_out.upper = 1'b0;
        next_out.pend = 1'b0;
        // map only carries data in unencoded mode
        if (next_out.enc)
          next_out.map = cammem_pkg::CAM_RST_MAP;
        else
          next_out.map = next_out.hold[15:0]; // RULE12
        next_out.hi_pend = ~next_out.enc; // RULE8
      end
      else if (next_out.hi_pend)
      begin
        next_out.valid = 1'b1;
        next_out.map = next_out.hold[31:16]; // RULE12
        next_out.upper = 1'b1; // RULE8
        next_out.hi_pend = 1'b0;
      end
      else
      begin
        next_out.upper = 1'b0;
      end
    end
  end

  // output side: its own enable and its own clear
  always_ff @(posedge sys_clk_in or posedge out_clear)
  begin
    if (out_clear)
      out_q <= '{valid: 1'b0, found: 1'b0, addr: cammem_pkg::CAM_RST_ADDR,
                 map: cammem_pkg::CAM_RST_MAP, upper: 1'b0,
                 hold: cammem_pkg::CAM_RST_HITS, pend: 1'b0, hi_pend: 1'b0,
                 enc: 1'b0}; // RULE3
    else
      out_q <= next_out; // RULE2
  end

  assign result_valid_out = out_q.valid;
  assign match_found_out = out_q.found;
  assign match_addr_out = out_q.addr;
  assign match_map_out = out_q.map;
  assign map_upper_out = out_q.upper;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [31:0] prev_src; // helper: hits the shown result was built from
  // follows the output enable, so a search arriving while a result is held
  // does not pull the reference away from what is still shown
  always_ff @(posedge sys_clk_in or posedge out_clear)
  begin
    if (out_clear)
      prev_src <= cammem_pkg::CAM_RST_HITS;
    else if (out_ena_in)
      prev_src <= src_hits;
  end

  property p_in_sampled;
    @(posedge sys_clk_in) disable iff (in_clear)
    ($past(in_ena_in) && !$past(in_clear)) |-> in_q.srch == $past(fetch_strobe_in)
      && in_q.key == $past(search_key_in) && in_q.wr == $past(write_strobe_in);
  endproperty
  a_in_sampled: assert property (p_in_sampled) // RULE1
    else $error("input not sampled on enabled edge");

  property p_out_hold;
    @(posedge sys_clk_in) disable iff (out_clear)
    !$past(out_ena_in) |-> $stable(match_map_out) && $stable(result_valid_out)
      && $stable(match_addr_out);
  endproperty
  a_out_hold: assert property (p_out_hold) // RULE2
    else $error("output changed without its enable");

  property p_in_hold;
    @(posedge sys_clk_in) disable iff (in_clear)
    !$past(in_ena_in) |-> $stable(in_q);
  endproperty
  a_in_hold: assert property (p_in_hold) // RULE3
    else $error("input registers changed without their enable");

  property p_global_clear;
    @(posedge sys_clk_in) disable iff (reset_in)
    global_clr_in |-> !result_valid_out && match_map_out == 16'h0000
      && !write_busy_out && !in_q.srch;
  endproperty
  a_global_clear: assert property (p_global_clear) // RULE4
    else $error("global clear left a register set");

  property p_enc_addr;
    @(posedge sys_clk_in) disable iff (out_clear)
    (result_valid_out && match_found_out && !map_upper_out && out_q.enc)
      |-> prev_src[match_addr_out]
      && (prev_src & ((32'h0000_0001 << match_addr_out) - 32'h0000_0001)) == 32'h0;
  endproperty
  a_enc_addr: assert property (p_enc_addr) // RULE7
    else $error("encoded address does not match");

  property p_found_flag;
    @(posedge sys_clk_in) disable iff (out_clear)
    (result_valid_out && !map_upper_out) |-> match_found_out == |prev_src;
  endproperty
  a_found_flag: assert property (p_found_flag) // RULE13
    else $error("match-found flag wrong");

  property p_low_half;
    @(posedge sys_clk_in) disable iff (out_clear)
    (result_valid_out && !map_upper_out && !out_q.enc)
      |-> match_map_out == prev_src[15:0] && out_q.hi_pend;
  endproperty
  a_low_half: assert property (p_low_half) // RULE12
    else $error("first map cycle is not words 0 to 15");

  property p_high_half;
    @(posedge sys_clk_in) disable iff (out_clear)
    (result_valid_out && map_upper_out) |-> match_map_out == prev_src[31:16]
      && $past(out_q.hi_pend);
  endproperty
  a_high_half: assert property (p_high_half) // RULE8
    else $error("second map cycle is not words 16 to 31");

endmodule : cammem_top

//--- bench/cammem_writer_model.sv
// fabric-side writer model that holds each write long enough to commit
`timescale 1ns/10ps
module cammem_writer_model (
  input wire logic sys_clk_in,
  output logic strobe_out,
  output logic [cammem_pkg::CAM_AW-1:0] addr_out,
  output logic [cammem_pkg::CAM_WIDTH-1:0] data_out,
  output logic [cammem_pkg::CAM_WIDTH-1:0] mask_out
);
  // ----------------------------------------------------------------
  // idle state
  // ----------------------------------------------------------------
  initial
  begin
    strobe_out = 1'b0;
    addr_out = 5'h00;
    data_out = 32'h0000_0000;
    mask_out = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // one write: callers keep stored words distinct for encoded reads
  // ----------------------------------------------------------------
  task automatic put(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    // masked words need one extra held cycle; one spare covers both
    n = (m != 32'h0000_0000) ? 4 : 3;
    @(posedge sys_clk_in);
    #1;
    strobe_out = 1'b1;
    addr_out = a;
    data_out = d;
    mask_out = m;
    repeat (n) @(posedge sys_clk_in);
    #1;
    strobe_out = 1'b0;
    // released address and data lines show junk; the mask keeps its last value
    addr_out = ~a;
    data_out = ~d;
    repeat (2) @(posedge sys_clk_in);
  endtask : put
endmodule : cammem_writer_model

//--- bench/cammem_top_tb.sv
// self-checking bench for the content-addressable memory tile
`timescale 1ns/10ps
module cammem_top_tb;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic global_clr_in = 1'b0;
  logic in_clr_in = 1'b0;
  logic in_ena_in = 1'b1;
  logic out_clr_in = 1'b0;
  logic out_ena_in = 1'b1;
  logic fetch_strobe_in = 1'b0;
  logic [31:0] search_key_in = 32'h0000_0000;
  logic encoded_sel_in = 1'b1;
  logic wr_strobe;
  logic [4:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] wr_mask;
  logic busy;
  logic valid;
  logic found;
  logic [4:0] maddr;
  logic [15:0] map;
  logic upper;
  int bad_count = 0;
  int total_checks = 0;

  // 200 MHz clock
  always #2.5 sys_clk_in = ~sys_clk_in;

  cammem_writer_model W (.sys_clk_in(sys_clk_in), .strobe_out(wr_strobe),
    .addr_out(wr_addr), .data_out(wr_data), .mask_out(wr_mask));

  cammem_top DUT (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .global_clr_in(global_clr_in), .in_clr_in(in_clr_in), .in_ena_in(in_ena_in),
    .out_clr_in(out_clr_in), .out_ena_in(out_ena_in), .write_strobe_in(wr_strobe),
    .wr_addr_in(wr_addr), .wr_data_in(wr_data), .wr_dont_care_in(wr_mask),
    .fetch_strobe_in(fetch_strobe_in), .search_key_in(search_key_in),
    .encoded_sel_in(encoded_sel_in), .write_busy_out(busy), .result_valid_out(valid),
    .match_found_out(found), .match_addr_out(maddr), .match_map_out(map),
    .map_upper_out(upper));

  // ----------------------------------------------------------------
  // compare tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  task automatic chk_vec(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_vec

  // one search; returns just after the first result edge
  task automatic search(input logic [31:0] key, input logic enc);
    @(posedge sys_clk_in);
    #1;
    fetch_strobe_in = 1'b1;
    search_key_in = key;
    encoded_sel_in = enc;
    @(posedge sys_clk_in);
    #1;
    fetch_strobe_in = 1'b0;
    search_key_in = ~key;
    @(posedge sys_clk_in);
    #1;
  endtask : search

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // watchdog: the whole run needs well under a thousand cycles
  // ----------------------------------------------------------------
  initial
  begin
    #20000;
    bad_count++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge sys_clk_in);
    #1;
    chk_bit("valid in reset", 1'b0, valid);
    chk_bit("busy in reset", 1'b0, busy);
    reset_in = 1'b0;
    W.put(5'h0c, 32'h1234_5678, 32'h0000_0000);
    W.put(5'h03, 32'h0bad_1111, 32'h0000_0000);
    // busy is looked at while the masked write is in its data step
    fork
      W.put(5'h14, 32'h0bad_0000, 32'h0000_ffff);
      begin
        repeat (3) @(posedge sys_clk_in);
        #1;
        chk_bit("busy in write", 1'b1, busy);
      end
    join
    search(32'h1234_5678, 1'b1);
    chk_bit("valid", 1'b1, valid);
    chk_vec("addr", 32'h0000_000c, 32'(maddr));
    chk_vec("map enc", 32'h0000_0000, 32'(map));
    search(32'h0bad_beef, 1'b1);
    chk_vec("masked addr", 32'h0000_0014, 32'(maddr));
    search(32'h0000_0000, 1'b1);
    chk_bit("no match", 1'b0, found);
    search(32'h0bad_1111, 1'b0);
    chk_vec("low map", 32'h0000_0008, 32'(map));
    chk_bit("low half", 1'b0, upper);
    @(posedge sys_clk_in);
    #1;
    chk_vec("high map", 32'h0000_0010, 32'(map));
    chk_bit("high half", 1'b1, upper);
    W.put(5'h0c, 32'hcafe_0001, 32'h0000_0000);
    search(32'h1234_5678, 1'b1);
    chk_bit("old word gone", 1'b0, found);
    // let the result cycle end first, or the gated output holds valid high
    @(posedge sys_clk_in);
    #1;
    out_ena_in = 1'b0;
    search(32'hcafe_0001, 1'b1);
    chk_bit("held output", 1'b0, valid);
    out_ena_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    chk_vec("late addr", 32'h0000_000c, 32'(maddr));
    search(32'hcafe_0001, 1'b1);
    out_clr_in = 1'b1;
    #1;
    chk_bit("out clear", 1'b0, found);
    out_clr_in = 1'b0;
    in_ena_in = 1'b0;
    search(32'hcafe_0001, 1'b1);
    chk_bit("input gated", 1'b0, valid);
    in_ena_in = 1'b1;
    search(32'hcafe_0001, 1'b1);
    // held across an edge so the clocked clear check sees it
    global_clr_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    chk_bit("global clear", 1'b0, valid);
    global_clr_in = 1'b0;
    in_clr_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    in_clr_in = 1'b0;
    search(32'hcafe_0001, 1'b1);
    chk_bit("after clears", 1'b1, found);
    tally_and_finish();
  end
endmodule : cammem_top_tb
